//--- src/rss_top.sv
// reset source sequencer: reset causes, power-up delays, q1 release
// assumes apb master on pclk; pins and analog flags are asynchronous
//
// Implementation choices: the APB interface to the registers and the register offsets.
module rss_top #(
  parameter int POWER_UP_TIMER_A_CYC = rss_pkg::POWER_UP_TIMER_A_MS * 1000 * rss_pkg::CLK_MHZ,
  parameter int POWER_UP_TIMER_B_CYC = rss_pkg::POWER_UP_TIMER_B_MS * 1000 * rss_pkg::CLK_MHZ,
  parameter int POWER_UP_TIMER_C_CYC = rss_pkg::POWER_UP_TIMER_C_MS * 1000 * rss_pkg::CLK_MHZ,
  parameter int GUARD_CYC = rss_pkg::GUARD_US * rss_pkg::CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_reset_pin_n_i,
  output logic ext_reset_pin_n_o,
  output logic ext_reset_pin_n_oe,
  input wire logic [2:0] bor_below,
  input wire logic osc_running,
  input wire logic ost_expired,
  input wire logic pll_lock,
  input wire logic sys_clk_ok,
  input wire logic sw_reset_req,
  input wire logic trap_lockup,
  input wire logic illegal_op,
  input wire logic wdt_timeout,
  input wire logic wdt_en,
  input wire logic cpu_sleep,
  input wire logic cpu_idle,
  output logic system_reset_line,
  output logic [2:0] clk_src_sel,
  output logic clock_fail_trap,
  output logic clk_hold,
  output logic ost_start,
  output logic wdt_wakeup,
  output logic low_power_rc_clock_run
);
  // ********************************
  // state
  // ********************************
  localparam int CW = rss_pkg::CNT_W;
  localparam logic [CW-1:0] BIAS_CNT = CW'(rss_pkg::BIAS_CYC);
  localparam logic [4:0] FILT_CNT = 5'(rss_pkg::FILT_CYC);
  localparam rss_pkg::rss_regs_t RST_VAL = '{
    state: rss_pkg::ST_BIAS, cnt: '0, phase: '0, s1: 8'hF1, s2: 8'hF1, filt: '0,
    ext_ff: 1'b0, bor_ff: 1'b0, cold: 1'b1, cause: rss_pkg::CAUSE_RST, cfg: rss_pkg::CFG_RST,
    clk_src: rss_pkg::CFG_RST[rss_pkg::F_OSCGRP+:3], cf: 1'b0, rst: 1'b1, hold_clk: 1'b0,
    trap: 1'b0, wake: 1'b0, ost_go: 1'b0, ost_blank: '0, low_power_rc_clock: 1'b1, pready: 1'b0, pslverr: 1'b0, prdata: '0};
  rss_pkg::rss_regs_t r_ff;
  rss_pkg::rss_regs_t nxt_r;
  logic ext_lvl;
  logic bor_lvl;
  logic hold_any;
  logic wdt_rst;
  logic wdt_wake;

  function automatic logic [CW-1:0] dly_cyc(input logic [1:0] sel, input logic xtal);
    case (sel)
      2'h1: dly_cyc = CW'(POWER_UP_TIMER_A_CYC);
      2'h2: dly_cyc = CW'(POWER_UP_TIMER_B_CYC);
      2'h3: dly_cyc = CW'(POWER_UP_TIMER_C_CYC);
      default: dly_cyc = xtal ? CW'(GUARD_CYC) : '0;
    endcase
  endfunction : dly_cyc

  // ********************************
  // next state
  // ********************************
  always_comb begin
    logic [CW-1:0] dly;
    logic [1:0] bsel;
    logic q1;
    logic fail;
    dly = dly_cyc(r_ff.cfg[rss_pkg::F_POWER_UP_TIMER+:2], r_ff.cfg[rss_pkg::F_XTAL]);
    bsel = r_ff.cfg[rss_pkg::F_BORSEL+:2];
    q1 = (r_ff.phase == rss_pkg::Q1_PH);
    fail = !r_ff.s2[rss_pkg::SY_OSC] || (r_ff.cfg[rss_pkg::F_XTAL] && !r_ff.s2[rss_pkg::SY_OST])
      || (r_ff.cfg[rss_pkg::F_PLL] && !r_ff.s2[rss_pkg::SY_LOCK]);
    nxt_r = r_ff;
    nxt_r.s1 = {sys_clk_ok, pll_lock, ost_expired, osc_running, bor_below, ext_reset_pin_n_i};
    nxt_r.s2 = r_ff.s1;
    nxt_r.phase = r_ff.phase + 2'h1;
    nxt_r.trap = 1'b0;
    nxt_r.wake = 1'b0;
    nxt_r.ost_go = 1'b0;
    // pin filter: low must persist before it counts
    if (r_ff.s2[rss_pkg::SY_PIN]) begin
      nxt_r.filt = '0;
    end else if (r_ff.filt != FILT_CNT) begin
      nxt_r.filt = r_ff.filt + 5'h1;
    end
    ext_lvl = (r_ff.filt == FILT_CNT);
    // threshold 3 folds onto the highest one
    if (bsel == 2'h3) begin
      bsel = 2'h2;
    end
    bor_lvl = r_ff.cfg[rss_pkg::F_BOREN] && r_ff.s2[rss_pkg::SY_BOR + int'(bsel)];
    nxt_r.ext_ff = ext_lvl;
    nxt_r.bor_ff = bor_lvl;
    wdt_rst = wdt_timeout && !cpu_sleep;
    wdt_wake = wdt_timeout && cpu_sleep;
    hold_any = bor_lvl || ext_lvl || sw_reset_req || trap_lockup || illegal_op || wdt_rst;
    // apb slave: one wait state, registered answer
    if (psel && penable && !r_ff.pready) begin
      nxt_r.pready = 1'b1;
      nxt_r.pslverr = 1'b0;
      case (paddr)
        rss_pkg::CAUSE_ADDR: nxt_r.prdata = {16'h0000, r_ff.cause};
        rss_pkg::CFG_ADDR: nxt_r.prdata = {16'h0000, r_ff.cfg};
        rss_pkg::OSC_ADDR: nxt_r.prdata = 32'({r_ff.clk_src, 6'h00, r_ff.s2[rss_pkg::SY_LOCK], 1'b0,
          r_ff.cf, 3'h0});
        default: begin
          nxt_r.prdata = '0;
          nxt_r.pslverr = 1'b1;
        end
      endcase
    end else begin
      nxt_r.pready = 1'b0;
      nxt_r.pslverr = 1'b0;
      nxt_r.prdata = '0;
    end
    if (psel && penable && r_ff.pready && pwrite) begin
      if (paddr == rss_pkg::CAUSE_ADDR) begin
        nxt_r.cause = pwdata[15:0] & rss_pkg::CAUSE_MASK;
      end
      if (paddr == rss_pkg::CFG_ADDR) begin
        nxt_r.cfg = pwdata[15:0] & rss_pkg::CFG_MASK;
      end
    end
    // blank the stale expired level while the start pulse crosses over
    if (r_ff.ost_blank != 3'h0) begin
      nxt_r.ost_blank = r_ff.ost_blank - 3'h1;
    end
    // clock hold ends on start-up timer and pll lock
    if (r_ff.hold_clk && r_ff.ost_blank == 3'h0 && r_ff.s2[rss_pkg::SY_OST]
        && (!r_ff.cfg[rss_pkg::F_PLL] || r_ff.s2[rss_pkg::SY_LOCK])) begin
      nxt_r.hold_clk = 1'b0;
    end
    // cause flags, hardware set wins over software write
    if (ext_lvl && !r_ff.ext_ff) begin
      nxt_r.cause[rss_pkg::C_EXTR] = 1'b1;
      nxt_r.cause[rss_pkg::C_WDTO] = 1'b0;
      nxt_r.cause[rss_pkg::C_SLEEP] = cpu_sleep;
      nxt_r.cause[rss_pkg::C_IDLE] = cpu_idle;
      if (!cpu_sleep && !cpu_idle) begin
        nxt_r.cause[rss_pkg::C_SWR] = 1'b0;
      end
    end
    if (sw_reset_req) begin
      nxt_r.cause[rss_pkg::C_EXTR] = 1'b0;
      nxt_r.cause[rss_pkg::C_SWR] = 1'b1;
      nxt_r.cause[rss_pkg::C_WDTO] = 1'b0;
      nxt_r.cause[rss_pkg::C_IDLE] = 1'b0;
      nxt_r.cause[rss_pkg::C_SLEEP] = 1'b0;
    end
    if (wdt_rst) begin
      nxt_r.cause[rss_pkg::C_EXTR] = 1'b0;
      nxt_r.cause[rss_pkg::C_SWR] = 1'b0;
      nxt_r.cause[rss_pkg::C_WDTO] = 1'b1;
      nxt_r.cause[rss_pkg::C_IDLE] = 1'b0;
      nxt_r.cause[rss_pkg::C_SLEEP] = 1'b0;
    end
    if (wdt_wake) begin
      nxt_r.cause[rss_pkg::C_WDTO] = 1'b1;
      nxt_r.cause[rss_pkg::C_SLEEP] = 1'b1;
      nxt_r.wake = 1'b1;
    end
    if (trap_lockup) begin
      nxt_r.cause[rss_pkg::C_TRAP] = 1'b1;
    end
    if (illegal_op) begin
      nxt_r.cause[rss_pkg::C_IOP] = 1'b1;
    end
    if (bor_lvl && !r_ff.bor_ff) begin
      nxt_r.cause[rss_pkg::C_POR] = 1'b0;
      nxt_r.cause[rss_pkg::C_BOR] = 1'b1;
      nxt_r.clk_src = r_ff.cfg[rss_pkg::F_OSCGRP+:3];
      nxt_r.cf = 1'b0;
      nxt_r.cold = 1'b1;
      nxt_r.low_power_rc_clock = 1'b1;
      if (r_ff.cfg[rss_pkg::F_XTAL]) begin
        nxt_r.hold_clk = 1'b1;
        nxt_r.ost_go = 1'b1;
        nxt_r.ost_blank = rss_pkg::OST_BLANK;
      end
    end
    // ********************************
    // sequencer
    // ********************************
    case (r_ff.state)
      rss_pkg::ST_BIAS: begin
        if (r_ff.cnt == BIAS_CNT - CW'(1)) begin
          nxt_r.cnt = '0;
          if (r_ff.cold && dly != '0) begin
            nxt_r.state = rss_pkg::ST_DELAY;
          end else begin
            nxt_r.state = rss_pkg::ST_SYNC;
          end
        end else begin
          nxt_r.cnt = r_ff.cnt + CW'(1);
        end
      end
      rss_pkg::ST_DELAY: begin
        if (r_ff.cnt == dly - CW'(1)) begin
          nxt_r.cnt = '0;
          nxt_r.state = rss_pkg::ST_SYNC;
        end else begin
          nxt_r.cnt = r_ff.cnt + CW'(1);
        end
      end
      rss_pkg::ST_SYNC: begin
        if (q1 && (r_ff.cfg[rss_pkg::F_CLOCK_FAIL_MONITOR] || r_ff.s2[rss_pkg::SY_CLK])) begin
          nxt_r.state = rss_pkg::ST_RUN;
          nxt_r.rst = 1'b0;
          nxt_r.cold = 1'b0;
          nxt_r.low_power_rc_clock = r_ff.cfg[rss_pkg::F_CLOCK_FAIL_MONITOR] || wdt_en || (r_ff.clk_src == rss_pkg::LOW_POWER_RC_CLOCK_GRP);
          if (r_ff.cfg[rss_pkg::F_CLOCK_FAIL_MONITOR] && fail && !hold_any) begin
            nxt_r.trap = 1'b1;
            nxt_r.clk_src = rss_pkg::FAST_RC_GRP;
            nxt_r.cf = 1'b1;
          end
        end
      end
      rss_pkg::ST_RUN: begin
        nxt_r.cnt = '0;
      end
      default: begin
        nxt_r.state = rss_pkg::ST_BIAS;
        nxt_r.cnt = '0;
      end
    endcase
    if (hold_any) begin
      nxt_r.state = rss_pkg::ST_BIAS;
      nxt_r.cnt = '0;
      nxt_r.rst = 1'b1;
    end
  end

  // power-on reset loads every field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= RST_VAL;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign ext_reset_pin_n_o = 1'b1;
  assign ext_reset_pin_n_oe = 1'b0;
  assign system_reset_line = r_ff.rst;
  assign clk_src_sel = r_ff.clk_src;
  assign clock_fail_trap = r_ff.trap;
  assign clk_hold = r_ff.hold_clk;
  assign ost_start = r_ff.ost_go;
  assign wdt_wakeup = r_ff.wake;
  assign low_power_rc_clock_run = r_ff.low_power_rc_clock;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  src_hold_a: assert property (hold_any |=> system_reset_line && r_ff.cnt == '0)
    else $error("reset source did not restart sequence");
  bias_wait_a: assert property ((r_ff.state == rss_pkg::ST_BIAS && !hold_any && r_ff.cnt != BIAS_CNT - CW'(1))
    |=> r_ff.state == rss_pkg::ST_BIAS)
    else $error("bias delay left early");
  q1_release_a: assert property ($fell(system_reset_line) |-> r_ff.phase == 2'h0
    && $past(r_ff.state) == rss_pkg::ST_SYNC)
    else $error("reset released off phase edge");
  pin_filter_a: assert property (r_ff.s2[rss_pkg::SY_PIN] |=> r_ff.filt == '0 ##1 !r_ff.ext_ff)
    else $error("short pin pulse passed filter");
  pin_quiet_a: assert property (!ext_reset_pin_n_oe)
    else $error("reset pin driven");
  bor_flag_a: assert property ((bor_lvl && !r_ff.bor_ff) |=> r_ff.cause[rss_pkg::C_BOR]
    && !r_ff.cause[rss_pkg::C_POR] && system_reset_line)
    else $error("brown-out flag wrong");
  fail_trap_a: assert property (clock_fail_trap |-> clk_src_sel == rss_pkg::FAST_RC_GRP
    && $fell(system_reset_line) && r_ff.cf)
    else $error("clock fail trap without fast rc");
  frozen_a: assert property ((r_ff.state == rss_pkg::ST_SYNC && !r_ff.cfg[rss_pkg::F_CLOCK_FAIL_MONITOR]
    && !r_ff.s2[rss_pkg::SY_CLK]) |=> system_reset_line)
    else $error("left reset without clock");
  wdt_wake_a: assert property ((wdt_wake && !hold_any) |=> wdt_wakeup && r_ff.cause[rss_pkg::C_WDTO]
    && r_ff.cause[rss_pkg::C_SLEEP] && $stable(system_reset_line))
    else $error("watchdog wake mishandled");
  pll_hold_a: assert property ((clk_hold && r_ff.cfg[rss_pkg::F_PLL] && !r_ff.s2[rss_pkg::SY_LOCK])
    |=> clk_hold)
    else $error("clock hold dropped before lock");

  sw_cause_a: assert property ((sw_reset_req && !wdt_rst) |=> r_ff.cause[rss_pkg::C_SWR]
    && !r_ff.cause[rss_pkg::C_EXTR] && !r_ff.cause[rss_pkg::C_WDTO] && system_reset_line)
    else $error("software reset cause wrong");
  wdt_cause_a: assert property (wdt_rst |=> r_ff.cause[rss_pkg::C_WDTO]
    && !r_ff.cause[rss_pkg::C_SWR] && !r_ff.cause[rss_pkg::C_EXTR] && system_reset_line)
    else $error("watchdog reset cause wrong");
  ext_cause_a: assert property ((ext_lvl && !r_ff.ext_ff && !sw_reset_req && !wdt_rst)
    |=> r_ff.cause[rss_pkg::C_EXTR] && r_ff.cause[rss_pkg::C_IDLE] == $past(cpu_idle))
    else $error("pin reset cause wrong");
  trap_cause_a: assert property (trap_lockup |=> r_ff.cause[rss_pkg::C_TRAP] && system_reset_line)
    else $error("trap lockup cause wrong");
  iop_cause_a: assert property (illegal_op |=> r_ff.cause[rss_pkg::C_IOP] && system_reset_line)
    else $error("illegal op cause wrong");
  wdt_run_a: assert property ((wdt_timeout && !cpu_sleep) |=> system_reset_line && !wdt_wakeup)
    else $error("watchdog timeout while running did not reset");

  ost_start_a: assert property ((bor_lvl && !r_ff.bor_ff && r_ff.cfg[rss_pkg::F_XTAL])
    |=> ost_start && clk_hold)
    else $error("brown-out did not start oscillator timer");
  ost_hold_a: assert property ((clk_hold && !r_ff.s2[rss_pkg::SY_OST]) |=> clk_hold)
    else $error("clock hold dropped before timer expiry");
  bor_clk_a: assert property ((bor_lvl && !r_ff.bor_ff && !(psel && penable && r_ff.pready && pwrite))
    |=> clk_src_sel == r_ff.cfg[rss_pkg::F_OSCGRP+:3])
    else $error("brown-out did not reselect clock");
  low_power_rc_clock_cold_a: assert property ((r_ff.cold && system_reset_line) |-> low_power_rc_clock_run)
    else $error("low power rc stopped before release");

  warm_skip_a: assert property ((r_ff.state == rss_pkg::ST_BIAS && r_ff.cnt == BIAS_CNT - CW'(1)
    && !hold_any && (!r_ff.cold || dly_cyc(r_ff.cfg[rss_pkg::F_POWER_UP_TIMER+:2], r_ff.cfg[rss_pkg::F_XTAL]) == '0))
    |=> r_ff.state == rss_pkg::ST_SYNC)
    else $error("zero delay did not skip to sync");
  cold_delay_a: assert property ((r_ff.state == rss_pkg::ST_BIAS && r_ff.cnt == BIAS_CNT - CW'(1)
    && !hold_any && r_ff.cold && dly_cyc(r_ff.cfg[rss_pkg::F_POWER_UP_TIMER+:2], r_ff.cfg[rss_pkg::F_XTAL]) != '0)
    |=> r_ff.state == rss_pkg::ST_DELAY)
    else $error("cold start skipped power-up delay");
  dly_run_a: assert property ((r_ff.state == rss_pkg::ST_DELAY && !hold_any
    && r_ff.cnt != dly_cyc(r_ff.cfg[rss_pkg::F_POWER_UP_TIMER+:2], r_ff.cfg[rss_pkg::F_XTAL]) - CW'(1))
    |=> r_ff.state == rss_pkg::ST_DELAY)
    else $error("power-up delay left early");

  rel_cov: cover property ($fell(system_reset_line));
  guard_cov: cover property (r_ff.state == rss_pkg::ST_DELAY && r_ff.cfg[rss_pkg::F_POWER_UP_TIMER+:2] == 2'h0);
  trap_cov: cover property (clock_fail_trap);
  bor_cov: cover property (bor_lvl && !r_ff.bor_ff);
  wake_cov: cover property (wdt_wakeup);
endmodule : rss_top

//--- src/rss_pkg.sv
// constants and types of the reset source sequencer
// assumes a 100 MHz pclk standing in for the slow rc clock
package rss_pkg;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_MHZ = 100;
  localparam int BIAS_US = 10;
  localparam int BIAS_CYC = BIAS_US * CLK_MHZ;
  localparam int POWER_UP_TIMER_A_MS = 4;
  localparam int POWER_UP_TIMER_B_MS = 16;
  localparam int POWER_UP_TIMER_C_MS = 64;
  localparam int GUARD_US = 100;
  localparam int FILT_NS = 200;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 23;
  localparam logic [1:0] Q1_PH = 2'h3;
  localparam logic [2:0] OST_BLANK = 3'h4;
  // ********************************
  // register map
  // ********************************
  localparam logic [11:0] CAUSE_ADDR = 12'h000;
  localparam logic [11:0] CFG_ADDR = 12'h004;
  localparam logic [11:0] OSC_ADDR = 12'h008;
  localparam int C_POR = 0;
  localparam int C_BOR = 1;
  localparam int C_IDLE = 2;
  localparam int C_SLEEP = 3;
  localparam int C_WDTO = 4;
  localparam int C_SWR = 6;
  localparam int C_EXTR = 7;
  localparam int C_IOP = 14;
  localparam int C_TRAP = 15;
  localparam logic [15:0] CAUSE_MASK = 16'hC0DF;
  localparam logic [15:0] CAUSE_RST = 16'h0003;
  localparam int F_POWER_UP_TIMER = 0;
  localparam int F_CLOCK_FAIL_MONITOR = 2;
  localparam int F_BOREN = 3;
  localparam int F_BORSEL = 4;
  localparam int F_OSCGRP = 6;
  localparam int F_XTAL = 9;
  localparam int F_PLL = 10;
  localparam logic [15:0] CFG_MASK = 16'h07FF;
  localparam logic [15:0] CFG_RST = 16'h004A;
  localparam logic [2:0] FAST_RC_GRP = 3'h1;
  localparam logic [2:0] LOW_POWER_RC_CLOCK_GRP = 3'h2;
  // synchroniser bit positions
  localparam int SY_PIN = 0;
  localparam int SY_BOR = 1;
  localparam int SY_OSC = 4;
  localparam int SY_OST = 5;
  localparam int SY_LOCK = 6;
  localparam int SY_CLK = 7;
  // ********************************
  // types
  // ********************************
  typedef enum logic [3:0] {
    ST_BIAS = 4'h1,
    ST_DELAY = 4'h2,
    ST_SYNC = 4'h4,
    ST_RUN = 4'h8
  } rss_state_t;
  typedef struct packed {
    rss_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [1:0] phase;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [4:0] filt;
    logic ext_ff;
    logic bor_ff;
    logic cold;
    logic [15:0] cause;
    logic [15:0] cfg;
    logic [2:0] clk_src;
    logic cf;
    logic rst;
    logic hold_clk;
    logic trap;
    logic wake;
    logic ost_go;
    logic [2:0] ost_blank;
    logic low_power_rc_clock;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rss_regs_t;
endpackage : rss_pkg

//--- sim/rss_core_model.sv
// partner model: core and system clock generator
// assumes one pclk domain and the sequencer's ost_start pulse
module rss_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ost_start,
  output logic osc_running,
  output logic ost_expired,
  output logic pll_lock,
  output logic sys_clk_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // oscillator start-up timer
  // ********************************
  // start-up outlasts a cold release so the monitor sees the timer unexpired and traps
  logic [11:0] ost_cnt_ff;
  assign osc_running = 1'b1;
  assign pll_lock = 1'b1;
  assign sys_clk_ok = 1'b1;
  assign ost_expired = (ost_cnt_ff == 12'h000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_cnt_ff <= 12'h000;
    end else if (ost_start) begin
      ost_cnt_ff <= 12'h7D0;
    end else if (ost_cnt_ff != 12'h000) begin
      ost_cnt_ff <= ost_cnt_ff - 12'h001;
    end
  end
endmodule : rss_core_model

//--- sim/tb_rss_top.sv
// testbench of the reset source sequencer
// assumes shortened delays 40/160/640/100 and the core model on the far side
module tb_rss_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // signals
  // ********************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ext_n = 1'b1;
  logic [2:0] bor = 3'h0;
  logic [3:0] src = 4'h0;
  logic sleep = 1'b0;
  logic idle = 1'b0;
  logic trap;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pin_o, pin_oe, osc_running, ost_expired, pll_lock, sys_clk_ok;
  logic system_reset_line, clk_hold, ost_start, wdt_wakeup, low_power_rc_clock_run;
  logic [2:0] clk_src_sel;
  logic [31:0] exp_c [4] = '{32'h40, 32'h8000, 32'h4000, 32'h10};
  logic [15:0] bcfg [2] = '{16'h0289, 16'h02EC};
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  rss_top #(.POWER_UP_TIMER_A_CYC(40), .POWER_UP_TIMER_B_CYC(160), .POWER_UP_TIMER_C_CYC(640), .GUARD_CYC(100)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_reset_pin_n_i(ext_n), .ext_reset_pin_n_o(pin_o), .ext_reset_pin_n_oe(pin_oe),
    .bor_below(bor), .osc_running(osc_running), .ost_expired(ost_expired), .pll_lock(pll_lock),
    .sys_clk_ok(sys_clk_ok), .sw_reset_req(src[0]), .trap_lockup(src[1]), .illegal_op(src[2]),
    .wdt_timeout(src[3]), .wdt_en(1'b0), .cpu_sleep(sleep), .cpu_idle(idle),
    .system_reset_line(system_reset_line), .clk_src_sel(clk_src_sel), .clock_fail_trap(trap),
    .clk_hold(clk_hold), .ost_start(ost_start), .wdt_wakeup(wdt_wakeup), .low_power_rc_clock_run(low_power_rc_clock_run)
  );
  rss_core_model u_core (
    .pclk(pclk), .presetn(presetn), .ost_start(ost_start), .osc_running(osc_running),
    .ost_expired(ost_expired), .pll_lock(pll_lock), .sys_clk_ok(sys_clk_ok)
  );
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  // ********************************
  // tasks
  // ********************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_rel(input int lo);
    int k;
    k = 0;
    while (system_reset_line !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    k = 0;
    while (system_reset_line !== 1'b0 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k >= lo && k <= lo + 12), 32'h1);
  endtask : wait_rel
  // ********************************
  // tests
  // ********************************
  initial begin
    repeat (8) @(posedge pclk);
    chk(32'(system_reset_line), 32'h1);
    chk(32'(low_power_rc_clock_run), 32'h1);
    presetn <= 1'b1;
    wait_rel(1160);
    apb(1'b0, rss_pkg::CAUSE_ADDR, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, rss_pkg::CFG_ADDR, 32'h0);
    chk(rd, 32'h4A);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b0, rss_pkg::OSC_ADDR, 32'h0);
    chk(rd & 32'h7020, 32'h1020);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, rss_pkg::CAUSE_ADDR, 32'h0);
      @(posedge pclk);
      src <= 4'h1 << k;
      @(posedge pclk);
      src <= 4'h0;
      wait_rel(1000);
      apb(1'b0, rss_pkg::CAUSE_ADDR, 32'h0);
      chk(rd, exp_c[k]);
      chk(32'(pin_oe), 32'h0);
    end
    apb(1'b1, rss_pkg::CAUSE_ADDR, 32'h0);
    ext_n <= 1'b0;
    repeat (10) @(posedge pclk);
    ext_n <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(system_reset_line), 32'h0);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, rss_pkg::CAUSE_ADDR, 32'h0);
      idle <= j[0];
      ext_n <= 1'b0;
      repeat (40) @(posedge pclk);
      ext_n <= 1'b1;
      idle <= 1'b0;
      wait_rel(1000);
      apb(1'b0, rss_pkg::CAUSE_ADDR, 32'h0);
      chk(rd, j == 0 ? 32'h80 : 32'h84);
    end
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, rss_pkg::CFG_ADDR, {16'h0, bcfg[k]});
      apb(1'b1, rss_pkg::CAUSE_ADDR, 32'h0);
      @(posedge pclk);
      bor <= 3'h1 << (2 * k);
      @(posedge pclk);
      bor <= 3'h0;
      repeat (8) @(posedge pclk);
      chk(32'(clk_hold), 32'h1);
      wait_rel(k == 0 ? 1040 - 8 : 1100 - 8);
      chk(32'(trap), 32'(k));
      apb(1'b0, rss_pkg::CAUSE_ADDR, 32'h0);
      chk(rd, 32'h2);
      chk(32'(clk_src_sel), k == 0 ? 32'h2 : 32'h1);
    end
    apb(1'b1, rss_pkg::CAUSE_ADDR, 32'h0);
    @(posedge pclk);
    sleep <= 1'b1;
    src <= 4'h8;
    @(posedge pclk);
    src <= 4'h0;
    n = 0;
    while (wdt_wakeup !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(wdt_wakeup), 32'h1);
    repeat (4) @(posedge pclk);
    chk(32'(system_reset_line), 32'h0);
    apb(1'b0, rss_pkg::CAUSE_ADDR, 32'h0);
    chk(rd, 32'h18);
    complete_run();
  end
endmodule : tb_rss_top
